// ---- hdl/swrb_core.sv ----
// Function
// - bus reset code, no parameter, makes reset pulse then presence window
// - sample line at short-detect and presence instants, report both flags
// - reset code while busy is not acknowledged and is dropped
// - reset finishes within reset low plus reset high plus 262.5ns
// - reset line activity starts within 262.5ns of ack-bit SCL fall
// - busy held for reset low plus high; flags update at their instants
// - both commands point the read pointer at the status register
// - slot code plus bit byte; 0 writes zero, 1 writes one or reads
// - each slot samples line at read-sample instant into result flag
// - slot code while busy: neither code nor bit byte acknowledged
// - slot finishes within one slot plus 262.5ns of MSB SCL fall
// - slot line activity starts within 262.5ns of MSB SCL fall
// - busy reads one for one slot duration; direction may change
`timescale 1ns/1ps
module swrb_core #(
	parameter int RSTL_STD = swrb_pkg::RSTL_STD_CYC,
	parameter int RSTH_STD = swrb_pkg::RSTH_STD_CYC,
	parameter int SI_STD = swrb_pkg::SI_STD_CYC,
	parameter int MSP_STD = swrb_pkg::MSP_STD_CYC,
	parameter int PDM_STD = swrb_pkg::PDM_STD_CYC,
	parameter int SLOT_STD = swrb_pkg::SLOT_STD_CYC,
	parameter int W0L_STD = swrb_pkg::W0L_STD_CYC,
	parameter int W1L_STD = swrb_pkg::W1L_STD_CYC,
	parameter int MSR_STD = swrb_pkg::MSR_STD_CYC,
	parameter int RSTL_OD = swrb_pkg::RSTL_OD_CYC,
	parameter int RSTH_OD = swrb_pkg::RSTH_OD_CYC,
	parameter int SI_OD = swrb_pkg::SI_OD_CYC,
	parameter int MSP_OD = swrb_pkg::MSP_OD_CYC,
	parameter int PDM_OD = swrb_pkg::PDM_OD_CYC,
	parameter int SLOT_OD = swrb_pkg::SLOT_OD_CYC,
	parameter int W0L_OD = swrb_pkg::W0L_OD_CYC,
	parameter int W1L_OD = swrb_pkg::W1L_OD_CYC,
	parameter int MSR_OD = swrb_pkg::MSR_OD_CYC,
	parameter int ACT_PULLUP = swrb_pkg::ACT_PULLUP_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire swrb_pkg::swrb_cfg_s cfg,
	input wire logic code_valid,
	input wire logic [7:0] code_byte,
	input wire logic bit_valid,
	input wire logic [7:0] bit_byte,
	input wire logic scl,
	input wire logic line_in,
	output logic code_ack,
	output logic byte_ack,
	output logic read_ptr_status,
	output swrb_pkg::swrb_status_s status,
	output logic line_out,
	output logic line_oe,
	output logic active_pullup_en,
	output logic strong_pullup_en
);
	import swrb_pkg::*;

	typedef enum {
		ST_IDLE,
		ST_WAIT_ACK_FALL,
		ST_WAIT_BIT,
		ST_WAIT_MSB_FALL,
		ST_RESET,
		ST_SLOT
	} swrb_state_e;

	swrb_state_e state;
	logic [15:0] t;
	logic [15:0] tn;
	logic fall_seen;
	logic slot_v;
	logic scl_fall;
	logic line_s;
	logic busy_any;
	logic accept;
	logic start_rst;
	logic start_slot;
	logic rst_end;
	logic slot_end;
	logic next_low;
	logic [15:0] act_pu_cnt;
	logic [15:0] c_rstl;
	logic [15:0] c_rsth;
	logic [15:0] c_si;
	logic [15:0] c_msp;
	logic [15:0] c_pdm;
	logic [15:0] c_slot;
	logic [15:0] c_w0l;
	logic [15:0] c_w1l;
	logic [15:0] c_msr;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	swrb_sync #(.INIT(1'b1)) u_scl_sync (
		.clk(clk),
		.rst(rst),
		.pin(scl),
		.level(),
		.fall(scl_fall)
	);

	swrb_sync #(.INIT(1'b1)) u_line_sync (
		.clk(clk),
		.rst(rst),
		.pin(line_in),
		.level(line_s),
		.fall()
	);

	// ----------------------------------------
	// speed-dependent timing
	// ----------------------------------------
	always_comb begin
		if (cfg.line_speed_select) begin
			c_rstl = 16'(RSTL_OD);
			c_rsth = 16'(RSTH_OD);
			c_si = 16'(SI_OD);
			c_msp = 16'(MSP_OD);
			c_pdm = 16'(PDM_OD);
			c_slot = 16'(SLOT_OD);
			c_w0l = 16'(W0L_OD);
			c_w1l = 16'(W1L_OD);
			c_msr = 16'(MSR_OD);
		end else begin
			c_rstl = 16'(RSTL_STD);
			c_rsth = 16'(RSTH_STD);
			c_si = 16'(SI_STD);
			c_msp = 16'(MSP_STD);
			c_pdm = 16'(PDM_STD);
			c_slot = 16'(SLOT_STD);
			c_w0l = 16'(W0L_STD);
			c_w1l = 16'(W1L_STD);
			c_msr = 16'(MSR_STD);
		end
	end

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	assign busy_any = (state != ST_IDLE);
	assign accept = code_valid && !busy_any &&
		(code_byte == CMD_BUS_RESET || code_byte == CMD_SINGLE_SLOT);
	// the second SCL fall after the code is the fall of its ack bit
	assign start_rst = (state == ST_WAIT_ACK_FALL) && scl_fall && fall_seen;
	assign start_slot = (state == ST_WAIT_MSB_FALL) && scl_fall;
	assign rst_end = (state == ST_RESET) && (t == c_rstl + c_rsth - 16'd1);
	assign slot_end = (state == ST_SLOT) && (t == c_slot - 16'd1);
	assign tn = t + 16'd1;

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			t <= 16'h0000;
			fall_seen <= 1'b0;
			slot_v <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					fall_seen <= 1'b0;
					if (accept && code_byte == CMD_BUS_RESET) begin
						state <= ST_WAIT_ACK_FALL;
					end else if (accept) begin
						state <= ST_WAIT_BIT;
					end
				end
				ST_WAIT_ACK_FALL: begin
					if (start_rst) begin
						state <= ST_RESET;
						t <= 16'h0000;
					end else if (scl_fall) begin
						fall_seen <= 1'b1;
					end
				end
				ST_WAIT_BIT: begin
					if (bit_valid) begin
						slot_v <= bit_byte[BIT_VALUE_POS];
						state <= ST_WAIT_MSB_FALL;
					end
				end
				ST_WAIT_MSB_FALL: begin
					// slot starts before the byte is complete
					if (start_slot) begin
						state <= ST_SLOT;
						t <= 16'h0000;
					end
				end
				ST_RESET: begin
					t <= tn;
					if (rst_end) begin
						state <= ST_IDLE;
					end
				end
				ST_SLOT: begin
					t <= tn;
					if (slot_end) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// line drive
	// ----------------------------------------
	always_comb begin
		next_low = 1'b0;
		if (start_rst || start_slot) begin
			next_low = 1'b1;
		end else if (state == ST_RESET && !rst_end) begin
			// mask hides the slave's presence falling edge
			next_low = (tn < c_rstl) || (cfg.presence_mask_select &&
				tn < c_rstl + c_pdm);
		end else if (state == ST_SLOT && !slot_end) begin
			next_low = tn < (slot_v ? c_w1l : c_w0l);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			line_oe <= 1'b0;
			line_out <= 1'b0;
		end else begin
			line_oe <= next_low;
			line_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// pullups
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			act_pu_cnt <= 16'h0000;
			active_pullup_en <= 1'b0;
		end else begin
			// speeds the rising edge after each release of the line
			if (line_oe && !next_low && cfg.active_pullup_select) begin
				act_pu_cnt <= 16'(ACT_PULLUP);
				active_pullup_en <= 1'b1;
			end else if (act_pu_cnt > 16'h0001) begin
				act_pu_cnt <= act_pu_cnt - 16'd1;
			end else begin
				act_pu_cnt <= 16'h0000;
				active_pullup_en <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			strong_pullup_en <= 1'b0;
		end else if (slot_end && cfg.strong_pullup_select) begin
			strong_pullup_en <= 1'b1;
		end else if (code_valid || !cfg.strong_pullup_select) begin
			strong_pullup_en <= 1'b0;
		end
	end

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			status <= '0;
		end else begin
			if (start_rst || start_slot) begin
				status.bus_busy_flag <= 1'b1;
			end else if (rst_end || slot_end) begin
				status.bus_busy_flag <= 1'b0;
			end
			if (state == ST_RESET && t == c_rstl + c_si) begin
				status.short_detected_flag <= !line_s;
			end
			if (state == ST_RESET && t == c_rstl + c_msp) begin
				status.presence_detected_flag <= !line_s;
			end
			if (state == ST_SLOT && t == c_msr) begin
				status.single_bit_result_flag <= line_s;
			end
		end
	end

	// ----------------------------------------
	// acknowledges and read pointer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			code_ack <= 1'b0;
			byte_ack <= 1'b0;
			read_ptr_status <= 1'b0;
		end else begin
			read_ptr_status <= accept;
			if (code_valid) begin
				code_ack <= accept;
				byte_ack <= 1'b0;
			end else if (bit_valid) begin
				byte_ack <= (state == ST_WAIT_BIT);
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	rst_start_a: assert property (
		start_rst |=> line_oe && status.bus_busy_flag)
		else $error("reset pulse did not start after ack fall");
	rst_low_len_a: assert property (
		$fell(line_oe) && state == ST_RESET &&
		!cfg.presence_mask_select |-> t == c_rstl)
		else $error("reset low has wrong length");
	short_samp_a: assert property (
		state == ST_RESET && t == c_rstl + c_si
		|=> status.short_detected_flag == !$past(line_s))
		else $error("short flag not sampled");
	pres_samp_a: assert property (
		state == ST_RESET && t == c_rstl + c_msp
		|=> status.presence_detected_flag == !$past(line_s))
		else $error("presence flag not sampled");
	// a refused code may meet the last busy cycle, which still ends the run
	busy_nack_a: assert property (
		code_valid && busy_any |=> !code_ack &&
		(state == $past(state) || $past(rst_end || slot_end)))
		else $error("command taken while busy");
	busy_len_a: assert property (
		$fell(status.bus_busy_flag) |-> $past(t) ==
		($past(state) == ST_RESET ? c_rstl + c_rsth - 16'd1
		: c_slot - 16'd1))
		else $error("busy period has wrong length");
	ptr_status_a: assert property (
		accept |=> read_ptr_status ##1 !read_ptr_status)
		else $error("read pointer not moved to status");
	slot_start_a: assert property (
		start_slot |=> line_oe &&
		state == ST_SLOT && status.bus_busy_flag)
		else $error("slot did not start on msb fall");
	slot_low_a: assert property (
		$fell(line_oe) && state == ST_SLOT
		|-> t == (slot_v ? c_w1l : c_w0l))
		else $error("slot low has wrong length");
	bit_samp_a: assert property (
		state == ST_SLOT && t == c_msr
		|=> status.single_bit_result_flag == $past(line_s))
		else $error("slot result not sampled");
	byte_nack_a: assert property (
		bit_valid && !code_valid &&
		state != ST_WAIT_BIT |=> !byte_ack)
		else $error("bit byte acked without slot command");
	strong_pu_a: assert property (
		slot_end && cfg.strong_pullup_select
		|=> strong_pullup_en)
		else $error("strong pullup not enabled after slot");

	reset_cycle_c: cover property (rst_end);
	read_slot_c: cover property (slot_end && slot_v);
	busy_refuse_c: cover property (code_valid && busy_any);

endmodule : swrb_core

// ---- hdl/swrb_sync.sv ----
`timescale 1ns/1ps
module swrb_sync #(
	parameter logic INIT = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	output logic level,
	output logic fall
);
	logic s1;
	logic s2;
	logic s3;

	// s1 feeds s2 only; edges are taken from the settled stages
	always_ff @(posedge clk) begin
		if (rst) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign level = s2;
	assign fall = s3 & ~s2;

endmodule : swrb_sync

// ---- include/swrb_pkg.sv ----
package swrb_pkg;

	// ----------------------------------------
	// command codes and bit byte layout
	// ----------------------------------------
	localparam logic [7:0] CMD_BUS_RESET = 8'hB4;
	localparam logic [7:0] CMD_SINGLE_SLOT = 8'h87;
	localparam int BIT_VALUE_POS = 7;

	// ----------------------------------------
	// clock and line timing, nanoseconds
	// ----------------------------------------
	localparam int CLK_NS = 100;
	localparam int START_MAX_NS = 262;

	localparam int RSTL_STD_NS = 560000;
	localparam int RSTH_STD_NS = 560000;
	localparam int SI_STD_NS = 8000;
	localparam int MSP_STD_NS = 68000;
	localparam int PDM_STD_NS = 2000;
	localparam int SLOT_STD_NS = 70000;
	localparam int W0L_STD_NS = 64000;
	localparam int W1L_STD_NS = 8000;
	localparam int MSR_STD_NS = 14000;

	localparam int RSTL_OD_NS = 70000;
	localparam int RSTH_OD_NS = 70000;
	localparam int SI_OD_NS = 1000;
	localparam int MSP_OD_NS = 8500;
	localparam int PDM_OD_NS = 500;
	localparam int SLOT_OD_NS = 10000;
	localparam int W0L_OD_NS = 8000;
	localparam int W1L_OD_NS = 1000;
	localparam int MSR_OD_NS = 1500;

	localparam int ACT_PULLUP_NS = 500;

	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc

	// ----------------------------------------
	// cycle counts
	// ----------------------------------------
	localparam int START_MAX_CYC = START_MAX_NS / CLK_NS;
	localparam int RSTL_STD_CYC = ns_to_cyc(RSTL_STD_NS);
	localparam int RSTH_STD_CYC = ns_to_cyc(RSTH_STD_NS);
	localparam int SI_STD_CYC = ns_to_cyc(SI_STD_NS);
	localparam int MSP_STD_CYC = ns_to_cyc(MSP_STD_NS);
	localparam int PDM_STD_CYC = ns_to_cyc(PDM_STD_NS);
	localparam int SLOT_STD_CYC = ns_to_cyc(SLOT_STD_NS);
	localparam int W0L_STD_CYC = ns_to_cyc(W0L_STD_NS);
	localparam int W1L_STD_CYC = ns_to_cyc(W1L_STD_NS);
	localparam int MSR_STD_CYC = ns_to_cyc(MSR_STD_NS);
	localparam int RSTL_OD_CYC = ns_to_cyc(RSTL_OD_NS);
	localparam int RSTH_OD_CYC = ns_to_cyc(RSTH_OD_NS);
	localparam int SI_OD_CYC = ns_to_cyc(SI_OD_NS);
	localparam int MSP_OD_CYC = ns_to_cyc(MSP_OD_NS);
	localparam int PDM_OD_CYC = ns_to_cyc(PDM_OD_NS);
	localparam int SLOT_OD_CYC = ns_to_cyc(SLOT_OD_NS);
	localparam int W0L_OD_CYC = ns_to_cyc(W0L_OD_NS);
	localparam int W1L_OD_CYC = ns_to_cyc(W1L_OD_NS);
	localparam int MSR_OD_CYC = ns_to_cyc(MSR_OD_NS);
	localparam int ACT_PULLUP_CYC = ns_to_cyc(ACT_PULLUP_NS);

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic line_speed_select;
		logic active_pullup_select;
		logic presence_mask_select;
		logic strong_pullup_select;
	} swrb_cfg_s;

	typedef struct packed {
		logic bus_busy_flag;
		logic presence_detected_flag;
		logic short_detected_flag;
		logic single_bit_result_flag;
	} swrb_status_s;

endpackage : swrb_pkg

// ---- verification/swrb_core_tb.sv ----
`timescale 1ns/1ps
module swrb_core_tb;
	import swrb_pkg::*;
	// shortened counts keep the run brief; all expectations use these
	localparam int RL = 60, RH = 60, SI = 8, MP = 22, PD = 4, SL = 40;
	localparam int W0 = 20, W1 = 5, MR = 12;
	localparam int RLF = 30, RHF = 30, SIF = 8, MPF = 18, PDF = 2;
	localparam int SLF = 20, W0F = 10, W1F = 3, MRF = 8;

	typedef struct packed {
		logic slot;
		swrb_cfg_s cfg;
		logic [7:0] bb;
		logic [2:0] far;
		logic [2:0] flags;
	} swrb_row_s;

	logic clk, rst, code_valid, bit_valid, scl, line_w, slave_pull;
	logic [7:0] code_byte, bit_byte;
	logic [2:0] far;
	swrb_cfg_s cfg;
	swrb_status_s status;
	logic code_ack, byte_ack, read_ptr_status, line_out, line_oe;
	logic active_pullup_en, strong_pullup_en, act_pu_seen;
	int num_errors = 0;
	int check_count = 0;
	int lat, oe_n, busy_n, rp;

	// far = {present, shorted, answer}, flags = {presence, short, result}
	swrb_row_s rows [9] = '{
		'{1'h0, 4'h0, 8'h00, 3'h4, 3'h4},
		'{1'h0, 4'h0, 8'h00, 3'h0, 3'h0},
		'{1'h0, 4'h0, 8'h00, 3'h2, 3'h6},
		'{1'h0, 4'hE, 8'h00, 3'h4, 3'h4},
		'{1'h1, 4'h0, 8'h80, 3'h5, 3'h1},
		'{1'h1, 4'h1, 8'hFF, 3'h4, 3'h0},
		'{1'h1, 4'h4, 8'h00, 3'h5, 3'h0},
		'{1'h1, 4'hD, 8'h80, 3'h5, 3'h1},
		'{1'h1, 4'h8, 8'h7F, 3'h5, 3'h0}
	};

	swrb_core #(.RSTL_STD(RL), .RSTH_STD(RH), .SI_STD(SI), .MSP_STD(MP),
		.PDM_STD(PD), .SLOT_STD(SL), .W0L_STD(W0), .W1L_STD(W1),
		.MSR_STD(MR), .RSTL_OD(RLF), .RSTH_OD(RHF), .SI_OD(SIF),
		.MSP_OD(MPF), .PDM_OD(PDF), .SLOT_OD(SLF), .W0L_OD(W0F),
		.W1L_OD(W1F), .MSR_OD(MRF)) dut_u (
		.clk(clk), .rst(rst), .cfg(cfg), .code_valid(code_valid),
		.code_byte(code_byte), .bit_valid(bit_valid), .bit_byte(bit_byte),
		.scl(scl), .line_in(line_w), .code_ack(code_ack),
		.byte_ack(byte_ack), .read_ptr_status(read_ptr_status),
		.status(status), .line_out(line_out), .line_oe(line_oe),
		.active_pullup_en(active_pullup_en),
		.strong_pullup_en(strong_pullup_en)
	);

	swrb_slave_model slave_u (.clk(clk), .master_pull(line_oe),
		.present(far[2]), .shorted(far[1]), .resp(far[0]),
		.pull(slave_pull));

	// open-drain line with pull-up: low if either side pulls
	assign line_w = (line_oe ? line_out : 1'h1) & ~slave_pull;

	always #50 clk = ~clk;

	always @(posedge clk) begin
		if (line_oe)
			oe_n++;
		if (status.bus_busy_flag)
			busy_n++;
		if (active_pullup_en)
			act_pu_seen = 1'h1;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	task automatic send_code(input logic [7:0] c);
		code_valid = 1'h1;
		code_byte = c;
		rp = 0;
		@(negedge clk);
		code_valid = 1'h0;
		rp += read_ptr_status;
		@(negedge clk);
		rp += read_ptr_status;
	endtask : send_code

	task automatic scl_half(input logic v);
		scl = v;
		repeat (4) @(negedge clk);
	endtask : scl_half

	task automatic start_line();
		oe_n = 0;
		busy_n = 0;
		act_pu_seen = 1'h0;
		lat = 0;
		scl = 1'h0;
		while (line_oe !== 1'h1 && lat < 20) begin
			@(negedge clk);
			lat++;
		end
	endtask : start_line

	task automatic wait_idle();
		int t;
		t = 0;
		while (status.bus_busy_flag !== 1'h0 && t < 400) begin
			@(negedge clk);
			t++;
		end
		// a busy flag that never drops is a failure of its own
		if (t >= 400)
			num_errors++;
		scl = 1'h1;
		repeat (4) @(negedge clk);
	endtask : wait_idle

	function automatic int exp_w(input swrb_row_s r, input logic busy);
		logic f;
		f = r.cfg.line_speed_select;
		if (busy)
			return r.slot ? (f ? SLF : SL) : (f ? RLF + RHF : RL + RH);
		if (r.slot)
			return r.bb[7] ? (f ? W1F : W1) : (f ? W0F : W0);
		return (f ? RLF : RL) + (r.cfg.presence_mask_select ? (f ? PDF : PD) : 0);
	endfunction : exp_w

	task automatic run_cmd(input swrb_row_s r);
		cfg = r.cfg;
		far = r.far;
		send_code(r.slot ? CMD_SINGLE_SLOT : CMD_BUS_RESET);
		check("code_ack", code_ack, 1);
		check("read_ptr", rp, 1);
		scl_half(1'h0);
		scl_half(1'h1);
		if (r.slot) begin
			scl_half(1'h0);
			scl = 1'h1;
			bit_valid = 1'h1;
			bit_byte = r.bb;
			@(negedge clk);
			bit_valid = 1'h0;
			repeat (3) @(negedge clk);
			check("byte_ack", byte_ack, 1);
		end
		start_line();
		check("start_lat", lat, 3);
		wait_idle();
		check("oe_width", oe_n, exp_w(r, 1'h0));
		check("line_out", line_out, 0);
		check("busy_len", busy_n, exp_w(r, 1'h1));
		if (r.slot)
			check("bit_result", status.single_bit_result_flag, r.flags[0]);
		else begin
			check("presence", status.presence_detected_flag, r.flags[2]);
			check("short", status.short_detected_flag, r.flags[1]);
		end
		check("active_pu", act_pu_seen, r.cfg.active_pullup_select);
		check("strong_pu", strong_pullup_en, r.slot & r.cfg[0]);
	endtask : run_cmd

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk = 1'h0;
		rst = 1'h1;
		cfg = '0;
		far = 3'h4;
		code_valid = 1'h0;
		code_byte = 8'h00;
		bit_valid = 1'h0;
		bit_byte = 8'h00;
		scl = 1'h1;
		repeat (2) @(negedge clk);
		rst = 1'h0;
		foreach (rows[i])
			run_cmd(rows[i]);
		// a code for another command is neither taken nor acknowledged here
		send_code(8'hA5);
		check("other_ack", code_ack, 0);
		check("other_ptr", rp, 0);
		// codes arriving mid-reset must be dropped without stretching it
		cfg = '0;
		send_code(CMD_BUS_RESET);
		scl_half(1'h0);
		scl_half(1'h1);
		start_line();
		repeat (10) @(negedge clk);
		send_code(CMD_BUS_RESET);
		check("busy_ack", code_ack, 0);
		check("busy_ptr", rp, 0);
		send_code(CMD_SINGLE_SLOT);
		check("busy_ack2", code_ack, 0);
		bit_valid = 1'h1;
		bit_byte = 8'h80;
		@(negedge clk);
		bit_valid = 1'h0;
		@(negedge clk);
		check("busy_byte", byte_ack, 0);
		wait_idle();
		check("busy_keep", busy_n, RL + RH);
		check("oe_keep", oe_n, RL);
		// reset in mid-cycle, then a clean command
		send_code(CMD_BUS_RESET);
		scl_half(1'h0);
		scl_half(1'h1);
		start_line();
		repeat (10) @(negedge clk);
		rst = 1'h1;
		repeat (2) @(negedge clk);
		rst = 1'h0;
		scl = 1'h1;
		check("rst_oe", line_oe, 0);
		check("rst_busy", status.bus_busy_flag, 0);
		repeat (30) @(negedge clk);
		run_cmd(rows[0]);
		give_verdict();
	end

	initial begin
		#(20000 * 100);
		num_errors++;
		give_verdict();
	end
endmodule : swrb_core_tb

// ---- verification/swrb_slave_model.sv ----
`timescale 1ns/1ps
module swrb_slave_model #(
	parameter int RST_MIN = 25,
	parameter int PD_WAIT = 10,
	parameter int PD_LEN = 16,
	parameter int RD_LEN = 16
) (
	input wire logic clk,
	input wire logic master_pull,
	input wire logic present,
	input wire logic shorted,
	input wire logic resp,
	output logic pull
);
	int low_n = 0;
	int rel_n = 0;
	int rd_n = 0;
	logic prev = 1'h0;
	logic armed = 1'h0;

	always @(posedge clk) begin
		prev <= master_pull;
		if (master_pull)
			low_n <= low_n + 1;
		else
			low_n <= 0;
		if (rd_n > 0)
			rd_n <= rd_n - 1;
		// a zero answer holds the line past the master's short low phase
		if (master_pull && !prev && !resp)
			rd_n <= RD_LEN;
		// only a long low phase counts as a reset, so write-0 slots stay quiet
		if (prev && !master_pull && low_n >= RST_MIN) begin
			rel_n <= 1;
			armed <= present;
		end else if (rel_n > 0 && rel_n < PD_WAIT + PD_LEN)
			rel_n <= rel_n + 1;
		else
			rel_n <= 0;
	end

	assign pull = shorted | (rd_n > 0) |
		(armed && rel_n >= PD_WAIT && rel_n < PD_WAIT + PD_LEN);
endmodule : swrb_slave_model
